// ===== pkg/gpio_pkg.sv
// Package: register map, mode codes and pin-group types for the GPIO port block
package gpio_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PORT_COUNT = 3;
  localparam int PINS_PER_PORT = 8;
  localparam int PIN_COUNT = 24;
  localparam int ADDR_W = 6;
  localparam int MODE_W = 4;

  // ****************************************
  // Register map (word addresses, block-local)
  // ****************************************
  localparam logic [5:0] PORT_STRIDE = 6'h08;
  localparam logic [2:0] OFS_MODE_LOW = 3'h0;
  localparam logic [2:0] OFS_MODE_HIGH = 3'h1;
  localparam logic [2:0] OFS_INPUT = 3'h2;
  localparam logic [2:0] OFS_OUTPUT = 3'h3;
  localparam logic [2:0] OFS_SET = 3'h4;
  localparam logic [2:0] OFS_CLEAR = 3'h5;
  localparam logic [2:0] OFS_WAKE = 3'h6;
  localparam logic [5:0] ADDR_DEBUG_CFG = 6'h18;
  localparam logic [5:0] ADDR_TIMER_OPT = 6'h19;
  localparam logic [5:0] ADDR_TIMER_EN = 6'h1a;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DBG_EXTREG_BIT = 0;
  localparam int DBG_DISABLE_BIT = 1;
  localparam int TOPT_CH_LSB = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] MODE_RESET = 16'h4444;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [1:0] DBG_RESET = 2'h1;
  localparam logic [7:0] TOPT_RESET = 8'h00;
  localparam logic [3:0] TEN_RESET = 4'h0;

  // ****************************************
  // Mode codes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_ANALOG = 4'h0,
    MODE_OUT_PP = 4'h1,
    MODE_IN_FLOAT = 4'h4,
    MODE_OUT_OD = 4'h5,
    MODE_IN_PULL = 4'h8,
    MODE_ALT_PP = 4'h9,
    MODE_ALT_SCLK = 4'hb,
    MODE_ALT_OD = 4'hd
  } pin_mode_t;

  // ****************************************
  // Pin-facing carriers
  // ****************************************
  typedef struct packed {
    logic [PIN_COUNT-1:0] out;
    logic [PIN_COUNT-1:0] oe;
    logic [PIN_COUNT-1:0] pull_up;
    logic [PIN_COUNT-1:0] pull_down;
    logic [PIN_COUNT-1:0] analog;
  } pad_ctrl_t;

  typedef struct packed {
    logic jtag_active;
    logic swd_active;
    logic jtag_data_out;
    logic swd_data_out;
    logic swd_data_oe;
  } debug_io_t;

endpackage

// ===== rtl/gpio_port_config_mux.sv
// Module: 24-pin GPIO block with mode decode, output muxing and forced functions
`timescale 1ns/1ns
`default_nettype none
// Operation
// (R1) 24 pins in three ports of eight, bit index is pin number
// (R2) Each pin has its own 4-bit mode field
// (R3) Low mode register holds pins 3..0, high register pins 7..4
// (R4) Mode 0x0 analog: input forced high, reads 1, output off
// (R5) Mode 0x4 floating digital input, no pulls, output off
// (R6) Mode 0x8 pulled input, output bit 1 pull-up, 0 pull-down
// (R7) Mode 0x1 push-pull from output register bit
// (R8) Mode 0x5 open-drain from output register bit
// (R9) Mode 0x9 push-pull from peripheral output
// (R10) Mode 0xD open-drain from peripheral output
// (R11) Mode 0xB push-pull alternate for SPI master clock pins
// (R12) Digitised input feeds input register, peripherals, wake and interrupt logic
// (R13) Exactly one output source; input and analog modes drive nothing
// (R14) Set and clear registers change only the written one bits
// (R15) Wake-enable register picks pins that may wake the device
// (R16) Enabled timer channels override serial controller outputs on shared pins
// (R17) Option bits 4..7 route channels to PA0,3,1,2 or PB1..4
// (R18) PA4 and PA5 carry packet trace or processor trace bits
// (R19) Alternate mode with no peripheral drives constant 0
// (R20) Regulator enable bit forces PA7 open-drain regulator output
// (R21) JTAG active forces PC0, PC2, PC3, PC4 functions
// (R22) Serial-wire active makes PC4 debugger-controlled data line
// (R23) Debug-disable bit releases PC0, PC2, PC3, PC4
// (R24) Reset: floating inputs, regulator bit set, debug-disable clear
// (R25) Undefined mode codes behave as analog
module gpio_port_config_mux (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [gpio_pkg::ADDR_W-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] i_pad_in,
  output gpio_pkg::pad_ctrl_t o_pad,
  output logic [gpio_pkg::PIN_COUNT-1:0] o_pin_level,
  output logic [gpio_pkg::PIN_COUNT-1:0] o_wake_enable,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] i_serial_out,
  input wire logic [3:0] i_timer_ch,
  input wire logic i_trace_sel,
  input wire logic i_packet_trace_enable,
  input wire logic i_packet_trace_data,
  input wire logic i_cpu_trace_bit_two,
  input wire logic i_cpu_trace_bit_three,
  input wire logic i_reg_enable,
  input wire gpio_pkg::debug_io_t i_debug
);

  // ****************************************
  // Functions
  // ****************************************
  // Undefined codes fold to analog
  function automatic gpio_pkg::pin_mode_t decode_mode(input logic [3:0] code);
    gpio_pkg::pin_mode_t m;
    unique case (code)
      4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hb, 4'hd: m = gpio_pkg::pin_mode_t'(code);
      default: m = gpio_pkg::MODE_ANALOG; // [R25]
    endcase
    return m;
  endfunction

  function automatic logic [7:0] port_byte(input logic [23:0] v, input logic [1:0] p);
    logic [7:0] b;
    unique case (p)
      2'd0: b = v[7:0];
      2'd1: b = v[15:8];
      default: b = v[23:16];
    endcase
    return b;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [3:0] mode_field [gpio_pkg::PIN_COUNT]; // [R1] [R2]
  logic [gpio_pkg::PIN_COUNT-1:0] port_output_value;
  logic [gpio_pkg::PIN_COUNT-1:0] port_wake_enable;
  logic [1:0] debug_config_register;
  logic [7:0] timer_option_register;
  logic [3:0] timer_channel_enable_register;
  logic [gpio_pkg::PIN_COUNT-1:0] port_input_level;

  logic [1:0] sel_port;
  logic [2:0] sel_reg;
  logic port_hit;
  assign sel_port = i_addr[4:3];
  assign sel_reg = i_addr[2:0];
  assign port_hit = (i_addr[5] == 1'b0) && (sel_port != 2'd3);

  // Mode fields: low register pins 3..0, high register pins 7..4
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int k = 0; k < gpio_pkg::PIN_COUNT; k++) begin
        mode_field[k] <= gpio_pkg::MODE_RESET[3:0]; // [R24]
      end
    end else if (i_wr && port_hit) begin
      for (int n = 0; n < 4; n++) begin
        if (sel_reg == gpio_pkg::OFS_MODE_LOW) begin
          mode_field[8 * sel_port + n] <= i_wdata[4*n +: 4]; // [R3]
        end
        if (sel_reg == gpio_pkg::OFS_MODE_HIGH) begin
          mode_field[8 * sel_port + n + 4] <= i_wdata[4*n +: 4]; // [R3]
        end
      end
    end
  end

  // Output register with atomic set and clear
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      port_output_value <= {gpio_pkg::PORT_COUNT{gpio_pkg::OUT_RESET}};
    end else if (i_wr && port_hit) begin
      for (int n = 0; n < 8; n++) begin
        unique case (sel_reg)
          gpio_pkg::OFS_OUTPUT: port_output_value[8 * sel_port + n] <= i_wdata[n];
          gpio_pkg::OFS_SET: begin
            if (i_wdata[n]) begin
              port_output_value[8 * sel_port + n] <= 1'b1; // [R14]
            end
          end
          gpio_pkg::OFS_CLEAR: begin
            if (i_wdata[n]) begin
              port_output_value[8 * sel_port + n] <= 1'b0; // [R14]
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      port_wake_enable <= {gpio_pkg::PORT_COUNT{gpio_pkg::WAKE_RESET}};
    end else if (i_wr && port_hit && sel_reg == gpio_pkg::OFS_WAKE) begin
      port_wake_enable[8 * sel_port +: 8] <= i_wdata[7:0]; // [R15]
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      debug_config_register <= gpio_pkg::DBG_RESET; // [R24]
      timer_option_register <= gpio_pkg::TOPT_RESET;
      timer_channel_enable_register <= gpio_pkg::TEN_RESET;
    end else if (i_wr) begin
      if (i_addr == gpio_pkg::ADDR_DEBUG_CFG) begin
        debug_config_register <= i_wdata[1:0];
      end
      if (i_addr == gpio_pkg::ADDR_TIMER_OPT) begin
        timer_option_register <= i_wdata[7:0];
      end
      if (i_addr == gpio_pkg::ADDR_TIMER_EN) begin
        timer_channel_enable_register <= i_wdata[3:0];
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      o_rdata <= 16'h0000;
      if (port_hit) begin
        unique case (sel_reg)
          gpio_pkg::OFS_MODE_LOW: begin
            for (int n = 0; n < 4; n++) begin
              o_rdata[4*n +: 4] <= mode_field[8 * sel_port + n];
            end
          end
          gpio_pkg::OFS_MODE_HIGH: begin
            for (int n = 0; n < 4; n++) begin
              o_rdata[4*n +: 4] <= mode_field[8 * sel_port + n + 4];
            end
          end
          gpio_pkg::OFS_INPUT: o_rdata[7:0] <= port_byte(port_input_level, sel_port);
          gpio_pkg::OFS_OUTPUT: o_rdata[7:0] <= port_byte(port_output_value, sel_port);
          gpio_pkg::OFS_WAKE: o_rdata[7:0] <= port_byte(port_wake_enable, sel_port);
          default: ;
        endcase
      end else if (i_addr == gpio_pkg::ADDR_DEBUG_CFG) begin
        o_rdata[1:0] <= debug_config_register;
      end else if (i_addr == gpio_pkg::ADDR_TIMER_OPT) begin
        o_rdata[7:0] <= timer_option_register;
      end else if (i_addr == gpio_pkg::ADDR_TIMER_EN) begin
        o_rdata[3:0] <= timer_channel_enable_register;
      end
    end
  end

  // ****************************************
  // Alternate source selection
  // ****************************************
  logic [gpio_pkg::PIN_COUNT-1:0] alt_value;
  logic [gpio_pkg::PIN_COUNT-1:0] alt_present;
  logic extreg_on;
  logic jtag_on;
  logic swd_on;
  assign extreg_on = debug_config_register[gpio_pkg::DBG_EXTREG_BIT];
  assign jtag_on = i_debug.jtag_active
    && !debug_config_register[gpio_pkg::DBG_DISABLE_BIT]; // [R23]
  assign swd_on = i_debug.swd_active
    && !debug_config_register[gpio_pkg::DBG_DISABLE_BIT]; // [R23]

  always_comb begin
    alt_value = i_serial_out;
    alt_present = '1;
    for (int c = 0; c < 4; c++) begin
      if (timer_channel_enable_register[c]) begin
        if (timer_option_register[gpio_pkg::TOPT_CH_LSB + c]) begin
          alt_value[8 + 1 + c] = i_timer_ch[c]; // [R16] [R17]
        end else begin
          unique case (c)
            0: alt_value[0] = i_timer_ch[c]; // [R17]
            1: alt_value[3] = i_timer_ch[c];
            2: alt_value[1] = i_timer_ch[c];
            default: alt_value[2] = i_timer_ch[c];
          endcase
        end
      end
    end
    alt_value[4] = i_trace_sel ? i_cpu_trace_bit_two : i_packet_trace_enable; // [R18]
    alt_value[5] = i_trace_sel ? i_cpu_trace_bit_three : i_packet_trace_data; // [R18]
    alt_present[7] = 1'b0;
  end

  // ****************************************
  // Per-pin mode decode and forcing
  // ****************************************
  gpio_pkg::pad_ctrl_t next_pad;
  logic [gpio_pkg::PIN_COUNT-1:0] next_level;

  always_comb begin
    gpio_pkg::pin_mode_t m;
    logic drive;
    m = gpio_pkg::MODE_ANALOG;
    drive = 1'b0;
    next_pad = '0;
    for (int k = 0; k < gpio_pkg::PIN_COUNT; k++) begin
      m = decode_mode(mode_field[k]);
      drive = alt_present[k] ? alt_value[k] : 1'b0; // [R19]
      unique case (m)
        gpio_pkg::MODE_ANALOG: next_pad.analog[k] = 1'b1; // [R4] [R13]
        gpio_pkg::MODE_IN_FLOAT: ; // [R5]
        gpio_pkg::MODE_IN_PULL: begin
          next_pad.pull_up[k] = port_output_value[k]; // [R6]
          next_pad.pull_down[k] = !port_output_value[k]; // [R6]
        end
        gpio_pkg::MODE_OUT_PP: begin
          next_pad.out[k] = port_output_value[k]; // [R7] [R13]
          next_pad.oe[k] = 1'b1;
        end
        gpio_pkg::MODE_OUT_OD: next_pad.oe[k] = !port_output_value[k]; // [R8]
        gpio_pkg::MODE_ALT_PP, gpio_pkg::MODE_ALT_SCLK: begin
          next_pad.out[k] = drive; // [R9] [R11]
          next_pad.oe[k] = 1'b1;
        end
        gpio_pkg::MODE_ALT_OD: next_pad.oe[k] = !drive; // [R10]
      endcase
    end
    if (extreg_on) begin
      next_pad.analog[7] = 1'b0; // [R20]
      next_pad.pull_up[7] = 1'b0;
      next_pad.pull_down[7] = 1'b0;
      next_pad.out[7] = 1'b0;
      next_pad.oe[7] = !i_reg_enable;
    end
    if (jtag_on) begin
      for (int k = 16; k <= 20; k++) begin
        if (k != 17) begin
          next_pad.analog[k] = 1'b0; // [R21]
          next_pad.pull_down[k] = 1'b0;
          next_pad.pull_up[k] = (k != 18);
          next_pad.out[k] = (k == 18) ? i_debug.jtag_data_out : 1'b0;
          next_pad.oe[k] = (k == 18);
        end
      end
    end else if (swd_on) begin
      next_pad.analog[20] = 1'b0; // [R22]
      next_pad.pull_up[20] = 1'b0;
      next_pad.pull_down[20] = 1'b0;
      next_pad.out[20] = i_debug.swd_data_out;
      next_pad.oe[20] = i_debug.swd_data_oe;
    end
    next_level = i_pad_in | next_pad.analog; // [R4] [R12]
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_pad <= '0;
      port_input_level <= '0;
      o_pin_level <= '0;
      o_wake_enable <= '0;
    end else begin
      o_pad <= next_pad;
      port_input_level <= next_level; // [R12]
      o_pin_level <= next_level; // [R12]
      o_wake_enable <= port_wake_enable; // [R15]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence set_write_s(int k);
    i_wr && port_hit && sel_reg == gpio_pkg::OFS_SET && i_wdata[k % 8] && sel_port == k / 8;
  endsequence

  set_bit_a: assert property (set_write_s(3) |=> port_output_value[3]) // [R14]
    else $error("set write did not set bit");
  clear_keep_a: assert property (i_wr && port_hit && sel_reg == gpio_pkg::OFS_CLEAR // [R14]
    && i_wdata[7:0] == 8'h03 && sel_port == 2'd0
    |=> port_output_value[1:0] == 2'b00
    && port_output_value[7:2] == $past(port_output_value[7:2]))
    else $error("clear write disturbed other bits");
  analog_read_a: assert property (decode_mode(mode_field[22]) == gpio_pkg::MODE_ANALOG // [R4]
    |=> port_input_level[22])
    else $error("analog pin did not read 1");
  analog_off_a: assert property (mode_field[22] == 4'h3 |=> !o_pad.oe[22]) // [R25]
    else $error("undefined mode drove pin");
  pull_dir_a: assert property (mode_field[22] == 4'h8 // [R6]
    |=> o_pad.pull_up[22] == $past(port_output_value[22]))
    else $error("pull direction wrong");
  pp_out_a: assert property (mode_field[22] == 4'h1 // [R7]
    |=> o_pad.oe[22] && o_pad.out[22] == $past(port_output_value[22]))
    else $error("push-pull output wrong");
  od_out_a: assert property (mode_field[22] == 4'h5 // [R8]
    |=> o_pad.oe[22] == !$past(port_output_value[22]))
    else $error("open-drain output wrong");
  input_off_a: assert property (mode_field[14] == 4'h4 |=> !o_pad.oe[14]) // [R5]
    else $error("input pin drove output");
  regen_force_a: assert property (extreg_on |=> !o_pad.out[7] && !o_pad.pull_up[7]) // [R20]
    else $error("regulator pin not open-drain");
  jtag_tdo_a: assert property (jtag_on |=> o_pad.oe[18] && o_pad.pull_up[16]) // [R21]
    else $error("jtag forcing missing");
  release_a: assert property (debug_config_register[gpio_pkg::DBG_DISABLE_BIT] // [R23]
    && mode_field[18] == 4'h1
    |=> o_pad.oe[18] && o_pad.out[18] == $past(port_output_value[18]))
    else $error("debug pin not released");
  timer_route_a: assert property (timer_channel_enable_register[0] // [R16] [R17]
    && timer_option_register[4] && mode_field[9] == 4'h9
    |=> o_pad.out[9] == $past(i_timer_ch[0]))
    else $error("timer channel one not routed");

endmodule // gpio_port_config_mux
`default_nettype wire

// ===== bench/gpio_pins_model.sv
// Pin-side model: resolves pad drive, pulls and outside level
`timescale 1ns/1ns
`default_nettype none
module gpio_pins_model (
  input wire gpio_pkg::pad_ctrl_t i_pad,
  input wire logic [gpio_pkg::PIN_COUNT-1:0] i_ext_level,
  output logic [gpio_pkg::PIN_COUNT-1:0] o_level
);
  // ****************************************
  // Wire level per pin
  // ****************************************
  always_comb begin
    for (int k = 0; k < gpio_pkg::PIN_COUNT; k++) begin
      if (i_pad.oe[k]) begin
        o_level[k] = i_pad.out[k];
      end else if (i_pad.pull_up[k]) begin
        o_level[k] = 1'b1;
      end else if (i_pad.pull_down[k]) begin
        o_level[k] = 1'b0;
      end else begin
        o_level[k] = i_ext_level[k];
      end
    end
  end
endmodule // gpio_pins_model
`default_nettype wire

// ===== bench/gpio_port_config_mux_tb_top.sv
// Testbench: register access, mode decode, muxing and forced pin functions
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check_eq(32'(g), 32'(e))
module gpio_port_config_mux_tb_top;
  logic i_core_clk;
  logic i_reset;
  logic i_wr;
  logic i_rd;
  logic [5:0] i_addr;
  logic [15:0] i_wdata;
  logic [15:0] o_rdata;
  logic [15:0] rdv;
  logic [23:0] pad_in;
  logic [23:0] ext;
  logic [23:0] pin_level;
  logic [23:0] wake_en;
  logic [23:0] ser;
  logic [3:0] tch;
  logic tsel, pte, ptd, ct2, ct3, regen;
  logic [4:0] e;
  gpio_pkg::pad_ctrl_t o_pad;
  gpio_pkg::debug_io_t dbg;
  int n_fail;
  int comparisons;

  gpio_port_config_mux uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pad_in(pad_in),
    .o_pad(o_pad), .o_pin_level(pin_level), .o_wake_enable(wake_en), .i_serial_out(ser),
    .i_timer_ch(tch), .i_trace_sel(tsel), .i_packet_trace_enable(pte),
    .i_packet_trace_data(ptd), .i_cpu_trace_bit_two(ct2), .i_cpu_trace_bit_three(ct3),
    .i_reg_enable(regen), .i_debug(dbg));
  gpio_pins_model pins (.i_pad(o_pad), .i_ext_level(ext), .o_level(pad_in));

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    @(posedge i_core_clk);
    d = o_rdata;
  endtask

  task automatic settle;
    repeat (4) @(posedge i_core_clk);
  endtask

  task automatic check_eq(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("BAD t=%0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Pad view {driven value, oe, pull up, pull down, analog}
  function automatic logic [4:0] exp_pin(input logic [3:0] m, input logic v);
    case (m)
      4'h4: return 5'b00000;
      4'h8: return {2'b00, v, ~v, 1'b0};
      4'h1, 4'h9, 4'hb: return {v, 4'b1000};
      4'h5, 4'hd: return v ? 5'b00000 : 5'b01000;
      default: return 5'b00001;
    endcase
  endfunction

  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  initial begin
    repeat (20000) @(posedge i_core_clk);
    n_fail++;
    $display("BAD t=%0t run too long", $time);
    finish_test;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {i_wr, i_rd, i_addr, i_wdata, ser, tch, tsel, pte, ptd, ct2, ct3, regen} = '0;
    dbg = '0;
    ext = '0;
    n_fail = 0;
    comparisons = 0;
    i_reset = 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    settle;
    `CHK(o_pad.oe, 24'h000080);
    for (int p = 0; p < 3; p++) begin
      rd(6'(8 * p), rdv);
      `CHK(rdv, 16'h4444);
      rd(6'(8 * p + 1), rdv);
      `CHK(rdv, 16'h4444);
    end
    rd(6'h18, rdv);
    `CHK(rdv, 16'h0001);
    wr(6'h00, 16'h1111);
    wr(6'h03, 16'h0005);
    wr(6'h04, 16'h000a);
    rd(6'h03, rdv);
    `CHK(rdv, 16'h000f);
    wr(6'h05, 16'h0003);
    rd(6'h03, rdv);
    `CHK(rdv, 16'h000c);
    rd(6'h04, rdv);
    `CHK(rdv, 16'h0000);
    settle;
    `CHK(o_pad.out[3:0], 4'hc);
    for (int i = 0; i < 32; i++) begin
      ser[22] <= 1'(i);
      if (i % 2 == 1) wr(6'h14, 16'h0040);
      else wr(6'h15, 16'h0040);
      wr(6'h11, {4'h4, 4'(i / 2), 8'h44});
      settle;
      e = exp_pin(4'(i / 2), 1'(i));
      `CHK({o_pad.out[22] & o_pad.oe[22], o_pad.oe[22], o_pad.pull_up[22], o_pad.pull_down[22],
            o_pad.analog[22]}, e);
      rd(6'h12, rdv);
      `CHK(rdv[6], e[0] | (e[3] ? e[4] : e[2]));
      `CHK(pin_level[22], e[0] | (e[3] ? e[4] : e[2]));
    end
    wr(6'h00, 16'h9999);
    wr(6'h08, 16'h9994);
    wr(6'h09, 16'h4449);
    ser <= '0;
    tch <= 4'b0110;
    wr(6'h1a, 16'h000f);
    settle;
    `CHK(o_pad.out[3:0], 4'ha);
    ser <= '1;
    wr(6'h19, 16'h00f0);
    settle;
    `CHK(o_pad.out[12:9], 4'h6);
    `CHK(o_pad.out[3:0], 4'hf);
    wr(6'h1a, 16'h0000);
    settle;
    `CHK(o_pad.out[12:9], 4'hf);
    wr(6'h01, 16'h4499);
    {tsel, pte, ptd, ct2, ct3} <= 5'b01001;
    settle;
    `CHK(o_pad.out[5:4], 2'b01);
    tsel <= 1'b1;
    settle;
    `CHK(o_pad.out[5:4], 2'b10);
    wr(6'h18, 16'h0000);
    wr(6'h01, 16'h9444);
    settle;
    `CHK({o_pad.oe[7], o_pad.out[7]}, 2'b10);
    wr(6'h18, 16'h0001);
    regen <= 1'b1;
    settle;
    `CHK(o_pad.oe[7], 1'b0);
    regen <= 1'b0;
    settle;
    `CHK({o_pad.oe[7], o_pad.out[7]}, 2'b10);
    wr(6'h10, 16'h1111);
    wr(6'h11, 16'h4441);
    dbg <= 5'b10100;
    settle;
    `CHK(o_pad.oe[20:16], 5'b00110);
    `CHK(o_pad.pull_up[20:16], 5'b11001);
    `CHK(o_pad.out[18], 1'b1);
    dbg <= 5'b01011;
    settle;
    `CHK(o_pad.oe[20:16], 5'b11111);
    `CHK(o_pad.out[20], 1'b1);
    dbg <= 5'b01000;
    settle;
    `CHK({o_pad.oe[20], o_pad.pull_up[20], o_pad.pull_down[20]}, 3'b000);
    dbg <= 5'b10100;
    wr(6'h18, 16'h0003);
    settle;
    `CHK({o_pad.oe[20:16], o_pad.out[20:16], o_pad.pull_up[20:16]}, 15'h7c00);
    wr(6'h0e, 16'h00a5);
    settle;
    `CHK(wake_en[15:8], 8'ha5);
    rd(6'h0e, rdv);
    `CHK(rdv, 16'h00a5);
    wr(6'h1f, 16'hffff);
    rd(6'h1f, rdv);
    `CHK(rdv, 16'h0000);
    finish_test;
  end
endmodule // gpio_port_config_mux_tb_top
`default_nettype wire
